/* File: pmc_pkg.sv */
// shared constants for the pcm slot and misc configuration block
package pmc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          REG_AW            = 7;
  localparam int          REG_DW            = 9;
  localparam logic [6:0]  ADDR_POWER_TRIM   = 7'h3A;
  localparam logic [6:0]  ADDR_LEFT_SLOT    = 7'h3B;
  localparam logic [6:0]  ADDR_MISC         = 7'h3C;
  localparam logic [6:0]  ADDR_RIGHT_SLOT   = 7'h3D;
  localparam logic [6:0]  ADDR_SILICON_STEP = 7'h3E;
  localparam logic [6:0]  ADDR_PART_ID      = 7'h3F;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [8:0]  RST_POWER_TRIM    = 9'h000;
  localparam logic [8:0]  RST_LEFT_SLOT     = 9'h000;
  localparam logic [8:0]  RST_MISC          = 9'h020;
  localparam logic [8:0]  RST_RIGHT_SLOT    = 9'h000;

  // writable bits of each register, reserved bits held at zero
  localparam logic [8:0]  MASK_POWER_TRIM   = 9'h0DF;
  localparam logic [8:0]  MASK_SLOT         = 9'h1FF;
  localparam logic [8:0]  MASK_MISC         = 9'h1FB;

  // ---------------------------------------------------------------
  // power trim fields
  // ---------------------------------------------------------------
  localparam int          PT_BOOST_HALF     = 7;
  localparam int          PT_CONV_HALF      = 6;
  localparam int          PT_MIC_LOW_NOISE  = 4;
  localparam int          PT_REG_LEVEL_LSB  = 2;
  localparam int          PT_BIAS_TRIM_LSB  = 0;

  // ---------------------------------------------------------------
  // misc fields
  // ---------------------------------------------------------------
  localparam int          MS_SLOT_ON        = 8;
  localparam int          MS_TRISTATE       = 7;
  localparam int          MS_SHORT_WORD     = 6;
  localparam int          MS_DRIVE_ON       = 5;
  localparam int          MS_PULL_ON        = 4;
  localparam int          MS_PULL_DIR       = 3;
  localparam int          MS_RIGHT_MSB      = 1;
  localparam int          MS_LEFT_MSB       = 0;

  // ---------------------------------------------------------------
  // serial word timing
  // ---------------------------------------------------------------
  localparam int          CNT_W             = 11;
  localparam int          WORD_BITS_DEF     = 24;
  localparam logic [10:0] SHORT_WORD_BITS   = 11'h008;
  localparam logic [10:0] CNT_MAX           = 11'h7FF;

endpackage

/* File: pmc_link_if.sv */
// link event carrier between the pin synchroniser and the core
`timescale 1ns/10ps
interface pmc_link_if;
  logic bclk_rise;
  logic fsync_level;

  modport src (output bclk_rise, output fsync_level);
  modport dst (input bclk_rise, input fsync_level);
endinterface

/* File: pmc_link_sync.sv */
// two-stage synchroniser for the bit clock and frame sync pins, edge finder for the bit clock
`timescale 1ns/10ps
module pmc_link_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // link pins
  input  wire logic link_bclk,
  input  wire logic link_fsync,
  // events towards the core
  pmc_link_if.src   ev
);

  typedef struct packed {
    logic bclk_meta;
    logic bclk_sync;
    logic bclk_prev;
    logic fs_meta;
    logic fs_sync;
  } pmc_sync_t;

  pmc_sync_t st_r;
  pmc_sync_t st_nxt;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.bclk_meta = link_bclk;
    st_nxt.bclk_sync = st_r.bclk_meta;
    st_nxt.bclk_prev = st_r.bclk_sync;
    st_nxt.fs_meta   = link_fsync;
    st_nxt.fs_sync   = st_r.fs_meta;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // only the second stage and later are looked at
  assign ev.bclk_rise   = st_r.bclk_sync & ~st_r.bclk_prev;
  assign ev.fsync_level = st_r.fs_sync;

endmodule

/* File: pmc_core.sv */
// pcm slot placement, output pin control and misc configuration registers
//
// What this block does
// R1: left word starts after a 10-bit bit-time count; msb in misc, low nine in left slot.
// R2: right word starts after a 10-bit bit-time count; msb in misc, low nine in right slot.
// R3: slot start counts apply only with slot enable set and pcm mode active.
// R4: with tri-state option, release the sample output after each word's last bit.
// R5: short-word option shifts 8-bit words instead of the normal word length.
// R6: driver enable 1 (reset) drives the sample output; 0 holds it high impedance.
// R7: pull enable 0 gives no resistor; 1 gives pull-up or pull-down by pull select.
// R8: misc resets to 0x020; slot and power registers reset to zero.
// R9: two-bit regulator level select, 00 normal, higher codes lower core voltage.
// R10: two-bit master bias trim, 00 normal, other codes reduce bias current.
// R11: separate half-current bits for converter and mix/boost amplifier.
// R12: mic bias mode bit selects normal or low-noise higher-impedance configuration.
// R13: revision register returns a fixed code; writes have no effect.
// R14: last register returns a fixed identity equal to the control bus address.
// R15: reserved bits read zero and ignore writes.
`timescale 1ns/10ps
module pmc_core #(
  parameter int         WORD_BITS         = pmc_pkg::WORD_BITS_DEF,
  // arbitrary neutral value, not any real part's revision
  parameter logic [8:0] SILICON_STEP_CODE = 9'h0A5,
  // arbitrary neutral value, stands for this device's control bus address
  parameter logic [8:0] PART_IDENTITY     = 9'h055
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset,
  // register port
  input  wire logic                          reg_sel,
  input  wire logic                          reg_we,
  input  wire logic [pmc_pkg::REG_AW-1:0]    reg_addr,
  input  wire logic [pmc_pkg::REG_DW-1:0]    reg_wdata,
  output logic      [pmc_pkg::REG_DW-1:0]    reg_rdata,
  // audio interface mode and sample words
  input  wire logic                          pcm_mode,
  input  wire logic [WORD_BITS-1:0]          left_word,
  input  wire logic [WORD_BITS-1:0]          right_word,
  // link pins
  input  wire logic                          link_bclk,
  input  wire logic                          link_fsync,
  output logic                               serial_sample_out,
  output logic                               serial_sample_oe_n,
  output logic                               sample_out_pull_up,
  output logic                               sample_out_pull_down,
  // analog section controls
  output logic [1:0]                         regulator_level_sel,
  output logic [1:0]                         master_bias_trim,
  output logic                               converter_half_current,
  output logic                               boost_amp_half_current,
  output logic                               mic_bias_low_noise
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // bit time falls inside the word that starts at start and runs len bits
  function automatic logic in_word(input logic [10:0] cnt,
                                   input logic [10:0] start,
                                   input logic [10:0] len);
    logic [11:0] stop;
    stop    = {1'b0, start} + {1'b0, len};
    in_word = (cnt >= start) && ({1'b0, cnt} < stop);
  endfunction

  // bit of a word for a given bit time, msb first
  function automatic logic word_bit(input logic [WORD_BITS-1:0] word,
                                    input logic [10:0]          cnt,
                                    input logic [10:0]          start);
    logic [10:0] offs;
    logic [10:0] pos;
    offs     = cnt - start;
    pos      = 11'(WORD_BITS - 1) - offs;
    word_bit = word[pos[$clog2(WORD_BITS)-1:0]];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [8:0]           power_trim_four;
    logic [8:0]           left_slot_low;
    logic [8:0]           pcm_output_misc;
    logic [8:0]           right_slot_low;
    logic [8:0]           rdata;
    logic [10:0]          bit_cnt;
    logic                 fs_prev;
    logic                 in_frame;
    logic [WORD_BITS-1:0] left_hold;
    logic [WORD_BITS-1:0] right_hold;
    logic                 out_bit;
    logic                 out_active;
  } pmc_core_t;

  pmc_core_t st_r;
  pmc_core_t st_nxt;

  pmc_link_if link ();

  pmc_link_sync u_sync (
    .clock      (clock),
    .reset      (reset),
    .link_bclk  (link_bclk),
    .link_fsync (link_fsync),
    .ev         (link.src)
  );

  // ---------------------------------------------------------------
  // decoded fields
  // ---------------------------------------------------------------
  logic        slot_placement_on;
  logic        tri_after_lsb;
  logic        short_word_sel;
  logic        sample_out_drive_on;
  logic        sample_out_pull_on;
  logic        sample_out_pull_dir;
  logic [9:0]  left_slot_start;
  logic [9:0]  right_slot_start;
  logic [10:0] word_len;
  logic [10:0] left_start;
  logic [10:0] right_start;
  logic        frame_start;
  logic [10:0] cnt_now;

  assign slot_placement_on   = st_r.pcm_output_misc[pmc_pkg::MS_SLOT_ON];
  assign tri_after_lsb       = st_r.pcm_output_misc[pmc_pkg::MS_TRISTATE];
  assign short_word_sel      = st_r.pcm_output_misc[pmc_pkg::MS_SHORT_WORD];
  assign sample_out_drive_on = st_r.pcm_output_misc[pmc_pkg::MS_DRIVE_ON];
  assign sample_out_pull_on  = st_r.pcm_output_misc[pmc_pkg::MS_PULL_ON];
  assign sample_out_pull_dir = st_r.pcm_output_misc[pmc_pkg::MS_PULL_DIR];

  // ten-bit starts assembled from the misc msb and the slot register
  assign left_slot_start  = {st_r.pcm_output_misc[pmc_pkg::MS_LEFT_MSB],
                             st_r.left_slot_low};                          // [R1]
  assign right_slot_start = {st_r.pcm_output_misc[pmc_pkg::MS_RIGHT_MSB],
                             st_r.right_slot_low};                         // [R2]

  assign word_len = short_word_sel ? pmc_pkg::SHORT_WORD_BITS
                                   : 11'(WORD_BITS);                       // [R5]

  // without slot placement the words sit back to back from frame sync
  always_comb begin
    if (slot_placement_on && pcm_mode) begin                               // [R3]
      left_start  = {1'b0, left_slot_start};                               // [R1]
      right_start = {1'b0, right_slot_start};                              // [R2]
    end else begin
      left_start  = 11'h000;
      right_start = word_len;
    end
  end

  assign frame_start = link.bclk_rise & link.fsync_level & ~st_r.fs_prev;
  assign cnt_now     = frame_start ? 11'h000 : st_r.bit_cnt;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // register writes; reserved bits masked, read-only addresses ignored
    if (reg_sel && reg_we) begin
      case (reg_addr)
        pmc_pkg::ADDR_POWER_TRIM: begin
          st_nxt.power_trim_four = reg_wdata & pmc_pkg::MASK_POWER_TRIM;   // [R15]
        end
        pmc_pkg::ADDR_LEFT_SLOT: begin
          st_nxt.left_slot_low = reg_wdata & pmc_pkg::MASK_SLOT;           // [R1]
        end
        pmc_pkg::ADDR_MISC: begin
          st_nxt.pcm_output_misc = reg_wdata & pmc_pkg::MASK_MISC;         // [R15]
        end
        pmc_pkg::ADDR_RIGHT_SLOT: begin
          st_nxt.right_slot_low = reg_wdata & pmc_pkg::MASK_SLOT;          // [R2]
        end
        default: begin
          st_nxt.rdata = st_r.rdata;                                       // [R13]
        end
      endcase
    end

    // read data registered; unmapped addresses read zero
    if (reg_sel && !reg_we) begin
      case (reg_addr)
        pmc_pkg::ADDR_POWER_TRIM:   st_nxt.rdata = st_r.power_trim_four;
        pmc_pkg::ADDR_LEFT_SLOT:    st_nxt.rdata = st_r.left_slot_low;
        pmc_pkg::ADDR_MISC:         st_nxt.rdata = st_r.pcm_output_misc;
        pmc_pkg::ADDR_RIGHT_SLOT:   st_nxt.rdata = st_r.right_slot_low;
        pmc_pkg::ADDR_SILICON_STEP: st_nxt.rdata = SILICON_STEP_CODE;      // [R13]
        pmc_pkg::ADDR_PART_ID:      st_nxt.rdata = PART_IDENTITY;          // [R14]
        default:                    st_nxt.rdata = 9'h000;
      endcase
    end

    // serial word engine, one step per bit clock rising edge
    if (link.bclk_rise) begin
      st_nxt.fs_prev = link.fsync_level;
      if (frame_start) begin
        // samples are caught at frame sync so a mid-frame update cannot tear a word
        st_nxt.in_frame   = 1'b1;
        st_nxt.left_hold  = left_word;
        st_nxt.right_hold = right_word;
      end
      if (frame_start || st_r.in_frame) begin
        if (in_word(cnt_now, left_start, word_len)) begin                  // [R1]
          st_nxt.out_bit    = word_bit(frame_start ? left_word : st_r.left_hold,
                                       cnt_now, left_start);
          st_nxt.out_active = 1'b1;
        end else if (in_word(cnt_now, right_start, word_len)) begin        // [R2]
          st_nxt.out_bit    = word_bit(frame_start ? right_word : st_r.right_hold,
                                       cnt_now, right_start);
          st_nxt.out_active = 1'b1;
        end else begin
          // a full lsb period has passed once the next bit edge arrives
          st_nxt.out_active = ~tri_after_lsb;                              // [R4]
        end
        // counter saturates so a missing frame sync cannot wrap into a slot
        if (cnt_now != pmc_pkg::CNT_MAX) begin
          st_nxt.bit_cnt = cnt_now + 11'h001;
        end else begin
          st_nxt.bit_cnt  = cnt_now;
          st_nxt.in_frame = 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r                 <= '0;
      st_r.power_trim_four <= pmc_pkg::RST_POWER_TRIM;                    // [R8]
      st_r.left_slot_low   <= pmc_pkg::RST_LEFT_SLOT;                     // [R8]
      st_r.pcm_output_misc <= pmc_pkg::RST_MISC;                          // [R8]
      st_r.right_slot_low  <= pmc_pkg::RST_RIGHT_SLOT;                    // [R8]
      st_r.out_active      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata         = st_r.rdata;
  assign serial_sample_out = st_r.out_bit;

  // driver off overrides everything, tri-state only idles outside words
  assign serial_sample_oe_n = ~(sample_out_drive_on & st_r.out_active);    // [R6] [R4]

  assign sample_out_pull_up   = sample_out_pull_on & sample_out_pull_dir;  // [R7]
  assign sample_out_pull_down = sample_out_pull_on & ~sample_out_pull_dir; // [R7]

  assign regulator_level_sel =
    st_r.power_trim_four[pmc_pkg::PT_REG_LEVEL_LSB +: 2];                  // [R9]
  assign master_bias_trim =
    st_r.power_trim_four[pmc_pkg::PT_BIAS_TRIM_LSB +: 2];                  // [R10]
  assign converter_half_current = st_r.power_trim_four[pmc_pkg::PT_CONV_HALF];  // [R11]
  assign boost_amp_half_current = st_r.power_trim_four[pmc_pkg::PT_BOOST_HALF]; // [R11]
  assign mic_bias_low_noise = st_r.power_trim_four[pmc_pkg::PT_MIC_LOW_NOISE];  // [R12]

endmodule

/* File: pmc_core_assertions.sv */
// port assertions for the pcm slot and misc configuration block
`timescale 1ns/10ps
module pmc_core_assertions #(
  parameter logic [8:0] SILICON_STEP_CODE = 9'h0A5,
  parameter logic [8:0] PART_IDENTITY     = 9'h055
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // register port
  input wire logic       reg_sel,
  input wire logic       reg_we,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic [8:0] reg_rdata,
  // pin and analog controls
  input wire logic       serial_sample_oe_n,
  input wire logic       sample_out_pull_up,
  input wire logic       sample_out_pull_down,
  input wire logic [1:0] regulator_level_sel,
  input wire logic [1:0] master_bias_trim,
  input wire logic       converter_half_current,
  input wire logic       boost_amp_half_current,
  input wire logic       mic_bias_low_noise
);
  logic       wr_misc;
  logic       wr_pwr;
  logic       rd_on;
  logic [8:0] wd_q;
  assign wr_misc = reg_sel && reg_we && reg_addr == pmc_pkg::ADDR_MISC;
  assign wr_pwr  = reg_sel && reg_we && reg_addr == pmc_pkg::ADDR_POWER_TRIM;
  assign rd_on   = reg_sel && !reg_we;
  // write data as it was one edge back, when the register took it
  always_ff @(posedge clock) begin
    wd_q <= reg_wdata;
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  pull_up_sel_a : assert property (
    wr_misc |=> sample_out_pull_up == (wd_q[4] && wd_q[3])) else $error("pull-up wrong");
  pull_down_sel_a : assert property (
    wr_misc |=> sample_out_pull_down == (wd_q[4] && !wd_q[3])) else $error("pull-down wrong");
  pull_exclusive_a : assert property (
    !(sample_out_pull_up && sample_out_pull_down)) else $error("both pulls on");
  drive_off_a : assert property (
    wr_misc && !reg_wdata[5] |-> ##[1:2] serial_sample_oe_n) else $error("pin still driven");
  regulator_code_a : assert property (
    wr_pwr |=> regulator_level_sel == wd_q[3:2]) else $error("regulator code wrong");
  regulator_hold_a : assert property (
    !wr_pwr |=> $stable(regulator_level_sel)) else $error("regulator code moved");
  bias_trim_code_a : assert property (
    wr_pwr |=> master_bias_trim == wd_q[1:0]) else $error("bias trim wrong");
  half_current_a : assert property (
    wr_pwr |=> {boost_amp_half_current, converter_half_current} == wd_q[7:6])
    else $error("half current bits wrong");
  mic_bias_mode_a : assert property (
    wr_pwr |=> mic_bias_low_noise == wd_q[4]) else $error("mic bias mode wrong");
  step_code_read_a : assert property (
    rd_on && reg_addr == 7'h3E |=> reg_rdata == SILICON_STEP_CODE) else $error("step code wrong");
  identity_read_a : assert property (
    rd_on && reg_addr == 7'h3F |=> reg_rdata == PART_IDENTITY) else $error("identity wrong");
  reserved_zero_a : assert property (
    rd_on && reg_addr == 7'h3A |=> !reg_rdata[8] && !reg_rdata[5]) else $error("reserved bit set");
endmodule

/* File: pmc_host_model.sv */
// host model: makes bit clock and frame sync, samples the sample pin
`timescale 1ns/10ps
module pmc_host_model (
  // link pins
  output logic      link_bclk,
  output logic      link_fsync,
  input  wire logic serial_sample_out,
  input  wire logic serial_sample_oe_n,
  input  wire logic sample_out_pull_up,
  input  wire logic sample_out_pull_down,
  // captured bits
  output logic      cap_strobe,
  output logic      cap_bit,
  output logic      cap_oe_n,
  output int        cap_idx
);
  logic last_w;
  initial begin
    link_bclk = 1'b0;
    link_fsync = 1'b0;
    cap_strobe = 1'b0;
    cap_bit = 1'b0;
    cap_oe_n = 1'b0;
    cap_idx = 0;
    last_w = 1'b0;
  end
  // bit clock stands still between frames; each bit is sampled just
  // before the next rise, where it has settled whatever the sync delay
  task automatic run_frame(input int n);
    logic w;
    #7;
    for (int k = 0; k <= n; k++) begin
      link_fsync = (k == 0);
      #80;
      if (k > 0) begin
        if (!serial_sample_oe_n) w = serial_sample_out;
        else if (sample_out_pull_up) w = 1'b1;
        else if (sample_out_pull_down) w = 1'b0;
        else w = ~last_w;
        last_w = w;
        cap_idx = k - 1;
        cap_oe_n = serial_sample_oe_n;
        cap_bit = w;
        cap_strobe = 1'b1;
      end
      #80;
      link_bclk = 1'b1;
      cap_strobe = 1'b0;
      #160;
      link_bclk = 1'b0;
    end
    link_fsync = 1'b0;
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the pcm slot and misc configuration block
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  typedef struct {int idx; logic [1:0] v;} pmc_note_t;
  localparam logic [8:0] STEP  = 9'h12C; // arbitrary
  localparam logic [8:0] IDENT = 9'h0B3; // arbitrary
  logic        clock, reset, reg_sel, reg_we, pcm_mode, rd_seen;
  logic [6:0]  reg_addr;
  logic [8:0]  reg_wdata, reg_rdata, d, exp_rd;
  logic [23:0] left_word, right_word;
  logic        link_bclk, link_fsync, sso, oe_n, pu, pd, chc, bhc, mbl;
  logic [1:0]  rls, mbt;
  logic        cap_strobe, cap_bit, cap_oe_n;
  int          cap_idx, n_errors, check_count;
  logic [31:0] seed, r;
  pmc_note_t   bq[$];
  pmc_note_t   note;
  logic [8:0]  rq[$];
  logic [6:0]  ta[7] = '{7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F, 7'h00};
  logic [8:0]  tv[7] = '{9'h000, 9'h000, 9'h020, 9'h000, STEP, IDENT, 9'h000};

  pmc_core #(.SILICON_STEP_CODE(STEP), .PART_IDENTITY(IDENT)) dut_u (
    .clock(clock), .reset(reset), .reg_sel(reg_sel), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pcm_mode(pcm_mode), .left_word(left_word), .right_word(right_word),
    .link_bclk(link_bclk), .link_fsync(link_fsync), .serial_sample_out(sso),
    .serial_sample_oe_n(oe_n), .sample_out_pull_up(pu), .sample_out_pull_down(pd),
    .regulator_level_sel(rls), .master_bias_trim(mbt), .converter_half_current(chc),
    .boost_amp_half_current(bhc), .mic_bias_low_noise(mbl));
  pmc_host_model host_u (
    .link_bclk(link_bclk), .link_fsync(link_fsync), .serial_sample_out(sso),
    .serial_sample_oe_n(oe_n), .sample_out_pull_up(pu), .sample_out_pull_down(pd),
    .cap_strobe(cap_strobe), .cap_bit(cap_bit), .cap_oe_n(cap_oe_n), .cap_idx(cap_idx));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic acc(input logic we, input logic [6:0] a, input logic [8:0] v);
    if (!we) rq.push_back(v);
    @(posedge clock);
    reg_sel <= 1'b1;
    reg_we <= we;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_sel <= 1'b0;
  endtask
  task automatic push_word(input int st, input logic [23:0] w, input int len,
                           input bit rel, input logic pv);
    for (int i = 0; i < len; i++) bq.push_back('{st + i, {1'b0, w[23 - i]}});
    if (rel) bq.push_back('{st + len, {1'b1, pv}});
  endtask
  task automatic frame_test(input int ls, input int rs, input int len,
                            input bit rel, input logic pv);
    logic [31:0] a, b;
    a = xs();
    b = xs();
    @(posedge clock);
    left_word <= a[23:0];
    right_word <= b[23:0];
    if (ls < rs) push_word(ls, a[23:0], len, rel, pv);
    push_word(rs, b[23:0], len, rel, pv);
    if (ls > rs) push_word(ls, a[23:0], len, rel, pv);
    @(posedge clock);
    host_u.run_frame((ls > rs ? ls : rs) + len + 2);
    `CHK(bq.size() == 0, 1'b1)
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // comparison of results against the oldest note
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    // pop once: the macro names its expected value twice on a mismatch
    if (rd_seen) begin
      exp_rd = rq.pop_front();
      `CHK(reg_rdata, exp_rd)
    end
    rd_seen <= reg_sel && !reg_we && !reset;
  end
  always @(posedge cap_strobe) begin
    if (bq.size() > 0 && bq[0].idx == cap_idx) begin
      note = bq.pop_front();
      `CHK({cap_oe_n, cap_bit}, note.v)
    end
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // all frames together take well under a millisecond
  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end
  initial begin
    {reset, reg_sel, reg_we, pcm_mode, rd_seen} = 5'b10010;
    {reg_addr, reg_wdata, left_word, right_word} = '0;
    {n_errors, check_count} = '0;
    seed = 32'h0F29C926;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) acc(1'b0, ta[i], tv[i]);
    done("reset values");
    for (int c = 0; c < 4; c++) begin
      r = xs();
      d = {r[8:4], c[1:0], ~c[1:0]};
      acc(1'b1, 7'h3A, d);
      acc(1'b0, 7'h3A, d & 9'h0DF);
    end
    acc(1'b1, 7'h3E, ~STEP);
    acc(1'b1, 7'h3F, ~IDENT);
    acc(1'b0, 7'h3E, STEP);
    acc(1'b0, 7'h3F, IDENT);
    acc(1'b1, 7'h3C, 9'h1FF);
    acc(1'b0, 7'h3C, 9'h1FB);
    done("registers");
    acc(1'b1, 7'h3C, 9'h020);
    frame_test(0, 24, 24, 1'b0, 1'b0);
    done("default placement");
    acc(1'b1, 7'h3B, 9'h001);
    acc(1'b1, 7'h3D, 9'h010);
    acc(1'b1, 7'h3C, 9'h1F9);
    frame_test(513, 16, 8, 1'b1, 1'b1);
    done("slot placement");
    @(posedge clock);
    pcm_mode <= 1'b0;
    acc(1'b1, 7'h3C, 9'h121);
    frame_test(0, 24, 24, 1'b0, 1'b0);
    done("slots outside pcm mode");
    acc(1'b1, 7'h3C, 9'h010);
    for (int i = 0; i < 8; i++) bq.push_back('{i, 2'b10});
    host_u.run_frame(10);
    `CHK(bq.size() == 0, 1'b1)
    done("driver off");
    end_sim();
  end
endmodule
bind pmc_core pmc_core_assertions #(
  .SILICON_STEP_CODE(SILICON_STEP_CODE), .PART_IDENTITY(PART_IDENTITY)) chk_u (
  .clock(clock), .reset(reset), .reg_sel(reg_sel), .reg_we(reg_we),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .serial_sample_oe_n(serial_sample_oe_n), .sample_out_pull_up(sample_out_pull_up),
  .sample_out_pull_down(sample_out_pull_down), .regulator_level_sel(regulator_level_sel),
  .master_bias_trim(master_bias_trim), .converter_half_current(converter_half_current),
  .boost_amp_half_current(boost_amp_half_current), .mic_bias_low_noise(mic_bias_low_noise));
